/* design/ptpac_pkg.sv */
/*
  Constants, register map and command codes of the PTP/OAM
  action comparator. Assumes a 32-bit APB master outside.
*/
// Summary of operation
// RULE1 - One header mask is shared by all flows; other settings are per flow.
// RULE2 - Each flow compares 64 match bits against header bytes 0 to 7.
// RULE3 - A 64-bit mask chooses which header bits take part in the compare.
// RULE4 - Mask bit one makes a bit significant; zero ignores that bit.
// RULE5 - Per-flow 8-bit lower and upper bounds; selected byte must lie within.
// RULE6 - Range check applies only while its per-flow enable is set.
// RULE7 - A 5-bit per-flow pointer picks the header byte for range checking.
// RULE8 - Code 0 does nothing; code 1 subtracts captured time from correction.
// RULE9 - Code 2: correction minus local latency plus path delay.
// RULE10 - Code 3: correction plus captured local time.
// RULE11 - Code 4: correction plus captured time plus latency minus stored time.
// RULE12 - Code 5: write captured local time into the time storage field.
// RULE13 - Code 6, legacy: path delay into storage and correction fields.
// RULE14 - Code 7: write nanosecond local time into the new field.
// RULE15 - Code 8: nanosecond time plus peer delay to new and correction field.
// RULE16 - Save bit set stores captured local time in the time stamp FIFO.
// RULE17 - 5-bit per-flow offset locates the correction field from header start.
// RULE18 - 6-bit per-flow offset locates the time storage field.
// RULE19 - Asymmetry add enable adds delay asymmetry to the correction field.
// RULE20 - Asymmetry deduct enable subtracts delay asymmetry from correction.
// RULE21 - 6-bit per-flow offset points at the first byte to clear.
// RULE22 - 4-bit per-flow count of bytes to clear; zero disables clearing.
// RULE23 - Action selection uses the first eight header bytes per flow.
// RULE24 - A flow's settings act only while its flow enable is set.
package ptpac_pkg;
  localparam int FLOWS = 4;
  localparam int FW = 2;
  localparam int HDR_BYTES = 32;
  // Byte addresses
  localparam logic [11:0] A_MASK_LO = 12'h000;
  localparam logic [11:0] A_MASK_HI = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;
  localparam logic [5:0] FLOW_PAGE = 6'h01;
  localparam logic [1:0] F_MLO = 2'h0;
  localparam logic [1:0] F_MHI = 2'h1;
  localparam logic [1:0] F_RNG = 2'h2;
  localparam logic [1:0] F_ACT = 2'h3;
  // Range word fields
  localparam int LO_LSB = 0;
  localparam int UP_LSB = 8;
  localparam int PTR_LSB = 16;
  localparam int REN_BIT = 23;
  localparam int FEN_BIT = 31;
  localparam logic [31:0] RNG_WMASK = 32'h809FFFFF;
  // Action word fields
  localparam int CMD_LSB = 0;
  localparam int SAVE_BIT = 4;
  localparam int ADD_BIT = 5;
  localparam int SUB_BIT = 6;
  localparam int CORR_LSB = 7;
  localparam int ZCNT_LSB = 12;
  localparam int TS_LSB = 16;
  localparam int ZOFF_LSB = 24;
  localparam logic [31:0] ACT_WMASK = 32'h3F3FFFFF;
  // Status word fields
  localparam int ST_VLD_BIT = 8;
  localparam int ST_CNT_LSB = 16;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  typedef enum logic [3:0] {
    CMD_IDLE_ACTION = 4'h0,
    CMD_DEDUCT_LOCAL_TIME = 4'h1,
    CMD_PEER_DELAY_DEDUCT = 4'h2,
    CMD_ADD_LOCAL_TIME = 4'h3,
    CMD_ADD_RESIDENCE = 4'h4,
    CMD_STORE_LOCAL_TIME = 4'h5,
    CMD_STORE_PEER_DELAY_LEGACY = 4'h6,
    CMD_PUT_NANOSECOND_TIME = 4'h7,
    CMD_PUT_NANOSECOND_PEER = 4'h8
  } ptpac_cmd_t;
endpackage

/* design/ptpac_top.sv */
/*
  PTP/OAM action comparator: APB register file, per-flow header
  match with range check, and the registered action command.
  Assumes header bytes arrive as one 32-byte word with a strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module ptpac_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  input wire logic hdr_valid_i,
  input wire logic [255:0] hdr_bytes_i,
  output logic act_valid_o,
  output logic act_hit_o,
  output logic [1:0] act_flow_o,
  output logic [3:0] act_cmd_o,
  output logic act_save_o,
  output logic [4:0] act_corr_off_o,
  output logic [5:0] act_ts_off_o,
  output logic act_asym_add_o,
  output logic act_asym_sub_o,
  output logic [5:0] act_zero_off_o,
  output logic [3:0] act_zero_cnt_o,
  output logic act_zero_en_o
);
  localparam int N = ptpac_pkg::FLOWS;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte 0 of the header sits in the top lane
  function automatic logic [7:0] sel_byte(input logic [255:0] h, input logic [4:0] p);
    sel_byte = h[8'(255 - 8 * int'(p)) -: 8];
  endfunction

  // Byte-lane merge of a write under pstrb
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = r & m;
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [31:0] mask_lo_r;
  logic [31:0] mask_hi_r;
  logic [31:0] mlo_r [N];
  logic [31:0] mhi_r [N];
  logic [31:0] rng_r [N];
  logic [31:0] act_r [N];
  logic [1:0] last_flow_r;
  logic last_vld_r;
  logic [15:0] hit_cnt_r;
  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Aligned word addresses only; anything else answers with an error
  wire setup_w = psel_i & ~penable_i;
  wire acc_w = psel_i & penable_i & pready_r;
  wire wr_w = acc_w & pwrite_i;
  wire aligned_w = (paddr_i[1:0] == 2'h0);
  wire flow_pg_w = aligned_w & (paddr_i[11:6] == ptpac_pkg::FLOW_PAGE);
  wire [1:0] fidx_w = paddr_i[5:4];
  wire [1:0] freg_w = paddr_i[3:2];
  wire hit_mlo_w = (paddr_i == ptpac_pkg::A_MASK_LO);
  wire hit_mhi_w = (paddr_i == ptpac_pkg::A_MASK_HI);
  wire hit_st_w = (paddr_i == ptpac_pkg::A_STATUS);
  wire mapped_w = hit_mlo_w | hit_mhi_w | hit_st_w | flow_pg_w;
  // Status is read-only; a write to it is refused
  wire err_w = ~mapped_w | (pwrite_i & hit_st_w);
  wire wr_ok_w = wr_w & ~err_w;

  wire [31:0] status_w = {hit_cnt_r, 7'h00, last_vld_r, 6'h00, last_flow_r};
  wire [31:0] flow_rd_w = (freg_w == ptpac_pkg::F_MLO) ? mlo_r[fidx_w] :
                          (freg_w == ptpac_pkg::F_MHI) ? mhi_r[fidx_w] :
                          (freg_w == ptpac_pkg::F_RNG) ? rng_r[fidx_w] : act_r[fidx_w];
  wire [31:0] rd_mux_w = hit_mlo_w ? mask_lo_r :
                         hit_mhi_w ? mask_hi_r :
                         hit_st_w ? status_w :
                         flow_pg_w ? flow_rd_w : ptpac_pkg::RST_WORD;

  // Answer is prepared in setup, so every access ends after one cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pready_r <= 1'b0;
      prdata_r <= ptpac_pkg::RST_WORD;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup_w;
      if (setup_w) begin
        prdata_r <= pwrite_i ? ptpac_pkg::RST_WORD : rd_mux_w;
        pslverr_r <= err_w;
      end
    end
  end

  // ----------------------------------------
  // Shared mask
  // ----------------------------------------
  // One mask for all flows [RULE1] [RULE3]
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_lo_r <= ptpac_pkg::RST_WORD;
      mask_hi_r <= ptpac_pkg::RST_WORD;
    end else begin
      if (wr_ok_w && hit_mlo_w) begin
        mask_lo_r <= merge(mask_lo_r, pwdata_i, pstrb_i, '1);
      end
      if (wr_ok_w && hit_mhi_w) begin
        mask_hi_r <= merge(mask_hi_r, pwdata_i, pstrb_i, '1);
      end
    end
  end

  // ----------------------------------------
  // Per-flow settings and match
  // ----------------------------------------
  wire [63:0] mask_w = {mask_hi_r, mask_lo_r};
  // First eight header bytes, byte 0 most significant [RULE2] [RULE23]
  wire [63:0] hdr64_w = hdr_bytes_i[255:192];
  logic [N-1:0] hit_w;

  genvar f;
  generate
    for (f = 0; f < N; f++) begin : g_flow
      wire sel_w = wr_ok_w & flow_pg_w & (fidx_w == 2'(f));
      // Separate match and action words per flow [RULE1]
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          mlo_r[f] <= ptpac_pkg::RST_WORD;
          mhi_r[f] <= ptpac_pkg::RST_WORD;
          rng_r[f] <= ptpac_pkg::RST_WORD;
          act_r[f] <= ptpac_pkg::RST_WORD;
        end else if (sel_w) begin
          case (freg_w)
            ptpac_pkg::F_MLO: mlo_r[f] <= merge(mlo_r[f], pwdata_i, pstrb_i, '1);
            ptpac_pkg::F_MHI: mhi_r[f] <= merge(mhi_r[f], pwdata_i, pstrb_i, '1);
            ptpac_pkg::F_RNG: rng_r[f] <= merge(rng_r[f], pwdata_i, pstrb_i,
                                                ptpac_pkg::RNG_WMASK);
            default: act_r[f] <= merge(act_r[f], pwdata_i, pstrb_i,
                                       ptpac_pkg::ACT_WMASK);
          endcase
        end
      end

      wire [63:0] mval_w = {mhi_r[f], mlo_r[f]};
      wire [7:0] lo_w = rng_r[f][ptpac_pkg::LO_LSB +: 8];
      wire [7:0] up_w = rng_r[f][ptpac_pkg::UP_LSB +: 8];
      wire [4:0] ptr_w = rng_r[f][ptpac_pkg::PTR_LSB +: 5];
      // Chosen byte, normally the domain [RULE7]
      wire [7:0] rbyte_w = sel_byte(hdr_bytes_i, ptr_w);
      // Only bits with mask zero may differ [RULE4] [RULE2]
      wire bits_ok_w = (((hdr64_w ^ mval_w) & mask_w) == 64'h0);
      // Inclusive bounds [RULE5], bypassed when disabled [RULE6]
      wire rng_ok_w = ~rng_r[f][ptpac_pkg::REN_BIT] | ((rbyte_w >= lo_w) & (rbyte_w <= up_w));
      // Disabled flow never matches [RULE24]
      assign hit_w[f] = rng_r[f][ptpac_pkg::FEN_BIT] & bits_ok_w & rng_ok_w;
    end
  endgenerate

  // ----------------------------------------
  // Flow priority
  // ----------------------------------------
  // Lowest flow wins when several match, so software can order rules
  function automatic logic [2:0] first_hit(input logic [N-1:0] h);
    logic [2:0] r;
    r = 3'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (h[i]) begin
        r = {1'b1, 2'(i)};
      end
    end
    first_hit = r;
  endfunction

  wire [2:0] pick_w = first_hit(hit_w);
  wire any_w = pick_w[2];
  wire [1:0] win_w = pick_w[1:0];
  wire [31:0] wact_w = act_r[win_w];
  wire [3:0] code_w = wact_w[ptpac_pkg::CMD_LSB +: 4];
  wire [3:0] zcnt_w = wact_w[ptpac_pkg::ZCNT_LSB +: 4];

  // Codes above the last defined one fall back to no action
  // [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] [RULE15]
  wire code_ok_w = (code_w <= 4'(ptpac_pkg::CMD_PUT_NANOSECOND_PEER));
  wire [3:0] cmd_w = code_ok_w ? code_w : 4'(ptpac_pkg::CMD_IDLE_ACTION);

  // ----------------------------------------
  // Action output
  // ----------------------------------------
  // One result per header strobe, one cycle later; a miss gives idle fields
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_valid_o <= 1'b0;
      act_hit_o <= 1'b0;
      act_flow_o <= 2'h0;
      act_cmd_o <= 4'h0;
      act_save_o <= 1'b0;
      act_corr_off_o <= 5'h00;
      act_ts_off_o <= 6'h00;
      act_asym_add_o <= 1'b0;
      act_asym_sub_o <= 1'b0;
      act_zero_off_o <= 6'h00;
      act_zero_cnt_o <= 4'h0;
      act_zero_en_o <= 1'b0;
    end else begin
      act_valid_o <= hdr_valid_i;
      if (hdr_valid_i) begin
        act_hit_o <= any_w;
        act_flow_o <= win_w;
        act_cmd_o <= any_w ? cmd_w : 4'h0;
        act_save_o <= any_w & wact_w[ptpac_pkg::SAVE_BIT]; // [RULE16]
        act_corr_off_o <= any_w ? wact_w[ptpac_pkg::CORR_LSB +: 5] : 5'h00; // [RULE17]
        act_ts_off_o <= any_w ? wact_w[ptpac_pkg::TS_LSB +: 6] : 6'h00; // [RULE18]
        act_asym_add_o <= any_w & wact_w[ptpac_pkg::ADD_BIT]; // [RULE19]
        act_asym_sub_o <= any_w & wact_w[ptpac_pkg::SUB_BIT]; // [RULE20]
        act_zero_off_o <= any_w ? wact_w[ptpac_pkg::ZOFF_LSB +: 6] : 6'h00; // [RULE21]
        act_zero_cnt_o <= any_w ? zcnt_w : 4'h0;
        act_zero_en_o <= any_w & (zcnt_w != 4'h0); // [RULE22]
      end
    end
  end

  // ----------------------------------------
  // Status
  // ----------------------------------------
  // Hit counter wraps; it is a debug aid, not an exact statistic
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_flow_r <= 2'h0;
      last_vld_r <= 1'b0;
      hit_cnt_r <= 16'h0000;
    end else if (hdr_valid_i && any_w) begin
      last_flow_r <= win_w;
      last_vld_r <= 1'b1;
      hit_cnt_r <= hit_cnt_r + 16'h0001;
    end
  end

  assign pready_o = pready_r;
  assign prdata_o = prdata_r;
  assign pslverr_o = pslverr_r;

endmodule // ptpac_top

`default_nettype wire

/* test/ptpac_asserts.sv */
/*
  Checker on the action comparator ports.
  Assumes a bind from the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module ptpac_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic hdr_valid_i,
  input wire logic act_valid_o,
  input wire logic act_hit_o,
  input wire logic [1:0] act_flow_o,
  input wire logic [3:0] act_cmd_o,
  input wire logic [3:0] act_zero_cnt_o,
  input wire logic act_zero_en_o
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  apb_ready_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  act_follow_a: assert property (hdr_valid_i |=> act_valid_o)
    else $error("header gave no result");
  act_only_a: assert property (!hdr_valid_i |=> !act_valid_o)
    else $error("result without header");
  miss_idle_a: assert property (act_valid_o && !act_hit_o |-> act_cmd_o == 4'h0
    && act_flow_o == 2'h0) else $error("miss carries an action");
  cmd_limit_a: assert property (act_valid_o |-> act_cmd_o <= 4'h8)
    else $error("action code above eight");
  zero_gate_a: assert property (act_valid_o |-> act_zero_en_o ==
    (act_hit_o && act_zero_cnt_o != 4'h0)) else $error("clear enable wrong");
  result_hold_a: assert property (!act_valid_o |-> $stable(act_cmd_o)
    && $stable(act_flow_o)) else $error("result changed between headers");
endmodule // ptpac_asserts
`default_nettype wire

/* test/ptpac_hdr_src.sv */
/*
  Model of the earlier comparator stage handing headers in.
  Assumes the bench calls send from its main thread.
*/
`timescale 1ns/1ps
`default_nettype none
module ptpac_hdr_src (
  input wire logic clk_i,
  output logic hdr_valid_o,
  output logic [255:0] hdr_bytes_o
);
  // Idle until the first header
  initial begin
    hdr_valid_o = 1'b0;
    hdr_bytes_o = 256'h0;
  end
  // One-cycle strobe; bytes turn over after it so stale data never looks valid
  task automatic send(input logic [255:0] b);
    @(posedge clk_i);
    hdr_valid_o <= 1'b1;
    hdr_bytes_o <= b;
    @(posedge clk_i);
    hdr_valid_o <= 1'b0;
    hdr_bytes_o <= ~b;
  endtask
endmodule // ptpac_hdr_src
`default_nettype wire

/* test/tb_top.sv */
/*
  Self-checking bench: APB master, header source, result checks.
  Assumes the design answers APB and headers as its note says.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pready_o, pslverr_o, rd_e;
  logic [11:0] paddr_i = 12'h000;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd_v;
  logic act_valid_o, act_hit_o, act_save_o, act_zero_en_o, act_asym_add_o, act_asym_sub_o;
  logic hdr_valid_i;
  logic [255:0] hdr_bytes_i;
  logic [1:0] act_flow_o;
  logic [3:0] act_cmd_o, act_zero_cnt_o;
  logic [4:0] act_corr_off_o;
  logic [5:0] act_ts_off_o, act_zero_off_o;
  int fail_count = 0, checks_done = 0, cycles = 0;
  ptpac_top dut (.clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .hdr_valid_i, .hdr_bytes_i,
    .act_valid_o, .act_hit_o, .act_flow_o, .act_cmd_o, .act_save_o, .act_corr_off_o,
    .act_ts_off_o, .act_asym_add_o, .act_asym_sub_o, .act_zero_off_o, .act_zero_cnt_o,
    .act_zero_en_o);
  ptpac_hdr_src src (.clk_i, .hdr_valid_o(hdr_valid_i), .hdr_bytes_o(hdr_bytes_i));
  // --------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // --------------------------------------------------------------
  always #10 clk_i = ~clk_i;
  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      close_out();
    end
  end
  task close_out;
    $display("Counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  // Request held until pready is seen at an edge; only the watchdog ends a wait
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rd_v = prdata_o;
    rd_e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  function logic [11:0] fa(input int f, input logic [1:0] o);
    return 12'h040 + 12'(16 * f) + {8'h00, o, 2'b00};
  endfunction
  task hit(input logic [63:0] h, input logic h_e, input logic [1:0] f_e, input logic [3:0] c_e);
    src.send({h, {6{32'hC3A55A3C}}});
    #1;
    chk({31'h0, act_valid_o}, 32'h1);
    chk({30'h0, act_flow_o, act_hit_o}, {30'h0, f_e, h_e});
    chk({28'h0, act_cmd_o}, {28'h0, c_e});
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_regs;
    apb(1'b0, ptpac_pkg::A_MASK_LO, 32'h0);
    chk(rd_v, ptpac_pkg::RST_WORD);
    apb(1'b1, fa(2, ptpac_pkg::F_ACT), 32'hFFFFFFFF);
    apb(1'b0, fa(2, ptpac_pkg::F_ACT), 32'h0);
    chk(rd_v, ptpac_pkg::ACT_WMASK);
    apb(1'b1, fa(2, ptpac_pkg::F_RNG), 32'hFFFFFFFF);
    apb(1'b0, fa(2, ptpac_pkg::F_RNG), 32'h0);
    chk(rd_v, ptpac_pkg::RNG_WMASK);
    // Strobe changes while the bus is idle; only byte lane 1 may land
    pstrb_i <= 4'h2;
    apb(1'b1, fa(2, ptpac_pkg::F_MLO), 32'hFFFFFFFF);
    pstrb_i <= 4'hF;
    apb(1'b0, fa(2, ptpac_pkg::F_MLO), 32'h0);
    chk(rd_v, 32'h0000FF00);
    apb(1'b1, fa(2, ptpac_pkg::F_RNG), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({rd_v[30:0], rd_e}, 32'h1);
    apb(1'b1, ptpac_pkg::A_STATUS, 32'hFFFFFFFF);
    chk({31'h0, rd_e}, 32'h1);
    $display("Register test ended");
  endtask
  task t_match;
    apb(1'b1, ptpac_pkg::A_MASK_HI, 32'hFFFF0000);
    apb(1'b1, fa(0, ptpac_pkg::F_MHI), 32'h12340000);
    apb(1'b1, fa(0, ptpac_pkg::F_RNG), 32'h80000000);
    apb(1'b1, fa(0, ptpac_pkg::F_ACT), 32'h00000003);
    hit(64'h123456789ABCDEF0, 1'b1, 2'h0, 4'h3);
    hit(64'h1235567800000000, 1'b0, 2'h0, 4'h0);
    apb(1'b1, ptpac_pkg::A_MASK_LO, 32'h000000FF);
    hit(64'h1234999999999900, 1'b1, 2'h0, 4'h3);
    hit(64'h1234000000000001, 1'b0, 2'h0, 4'h0);
    $display("Match test ended");
  endtask
  task t_range;
    logic [31:0] rb;
    rb = 32'h0405090A;
    apb(1'b1, fa(0, ptpac_pkg::F_RNG), 32'h80840905);
    for (int i = 0; i < 4; i++) begin
      hit({32'h12340000, rb[31-8*i -: 8], 24'h0}, i == 1 || i == 2, 2'h0,
        (i == 1 || i == 2) ? 4'h3 : 4'h0);
    end
    apb(1'b1, fa(0, ptpac_pkg::F_RNG), 32'h80850905);
    hit(64'h123400000A070000, 1'b1, 2'h0, 4'h3);
    apb(1'b1, fa(0, ptpac_pkg::F_RNG), 32'h80040905);
    hit(64'h123400000A000000, 1'b1, 2'h0, 4'h3);
    $display("Range test ended");
  endtask
  task t_codes;
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, fa(0, ptpac_pkg::F_ACT), 32'h152A39D0 | 32'(c));
      hit(64'h1234000000000000, 1'b1, 2'h0, c > 8 ? 4'h0 : 4'(c));
      chk({act_zero_off_o, act_ts_off_o, act_zero_cnt_o, act_corr_off_o, act_save_o,
        act_asym_add_o, act_asym_sub_o, act_zero_en_o}, {7'h0, 25'h0AD473B});
    end
    apb(1'b1, fa(0, ptpac_pkg::F_ACT), 32'h152A09B4);
    hit(64'h1234000000000000, 1'b1, 2'h0, 4'h4);
    chk({29'h0, act_asym_add_o, act_asym_sub_o, act_zero_en_o}, 32'h4);
    $display("Action code test ended");
  endtask
  task t_prio;
    apb(1'b1, fa(1, ptpac_pkg::F_MHI), 32'h12340000);
    apb(1'b1, fa(1, ptpac_pkg::F_RNG), 32'h80000000);
    apb(1'b1, fa(1, ptpac_pkg::F_ACT), 32'h00000005);
    hit(64'h1234777777777700, 1'b1, 2'h0, 4'h4);
    apb(1'b1, fa(0, ptpac_pkg::F_RNG), 32'h0);
    hit(64'h1234777777777700, 1'b1, 2'h1, 4'h5);
    $display("Priority test ended");
  endtask
  // Reset for five cycles, then every scenario in turn
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_match();
    t_range();
    t_codes();
    t_prio();
    close_out();
  end
endmodule // tb_top
bind ptpac_top ptpac_asserts u_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pready_o,
  .hdr_valid_i, .act_valid_o, .act_hit_o, .act_flow_o, .act_cmd_o, .act_zero_cnt_o,
  .act_zero_en_o);
`default_nettype wire
